// File: fcf_ctrl.sv
// host controller driving the flash command front end from wishbone registers
//
// Overview of operation
// RULE_01 - high-voltage id read: only A6, A1, A0 set, others zero.
// RULE_02 - protection verify: sector on upper bits, A1 high, A0 low.
// RULE_03 - same id data read in-system after the identify command sequence.
// RULE_04 - device refuses program or erase in locked sectors.
// RULE_05 - sectors are delivered unprotected.
// RULE_06 - unprotect only after every sector is known locked.
// RULE_07 - elevated clear pin temporarily unlocks protected sectors.
// RULE_08 - below supply threshold no write cycle is issued; the code checks supply only at command launch, not for the timeout auto reset.
// RULE_09 - write only with chip enable and strobe low, output enable high.
// RULE_10 - power-up leaves strobe and chip enable high, no command.
// RULE_11 - only defined address and data command sequences are sent.
// RULE_12 - address stable across later falling edge, data past first rise.
// RULE_13 - device starts and returns to read-array state by itself.
// RULE_14 - erase-suspended sectors read status, others array data.
// RULE_15 - host sends reset on timeout flag or to leave id mode.
// RULE_16 - reset command is accepted at any address.
// RULE_17 - reset between erase cycles aborts; ignored once erasing.
// RULE_18 - reset between program cycles aborts; ignored once programming.
// RULE_19 - only the reset command leaves identification mode.
// RULE_20 - timeout flag high: reset command returns to read array.
// RULE_21 - id offsets: maker 0, part 1 or 2, protection 2 or 4.
// RULE_22 - clear pin low ends everything; outputs float for its duration.
// RULE_23 - host keeps one protection bit per sector from verify reads.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fcf_ctrl
  import fcf_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [19:0] flash_addr_o,
  output logic      [15:0] flash_dq_o,
  output logic             flash_dq_oe_o,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic             flash_clear_n_o,
  output logic             flash_clear_hv_o,
  output logic             flash_id_hv_o,
  output logic             flash_word_mode_o,
  input  wire logic        supply_ok_i
);
  import fcf_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_WSET = 8'h02, ST_WLOW = 8'h04, ST_WHOLD = 8'h08,
    ST_RSET = 8'h10, ST_RWAIT = 8'h20, ST_CLR = 8'h40, ST_REC = 8'h80
  } fcf_st_t;

  typedef struct packed {
    fcf_st_t     st;
    fcf_op_t     op;
    logic [1:0]  stp;
    logic [7:0]  cnt;
    logic [2:0]  ctrl;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [18:0] prot;
    fcf_sel_t    sel;
    logic        hv;
    logic [4:0]  sidx;
    logic        idm;
    logic        err;
    logic        tmo;
    logic [19:0] fa;
    logic [15:0] fd;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        clr_n;
    logic        a_hv;
    logic        ack;
    logic [31:0] dat;
    logic        chv;
    logic        wm;
  } fcf_state_t;

  fcf_state_t  q;
  fcf_state_t  d;
  logic [15:0] dq_s;
  logic        sup_s;

  // ==========================================================
  // pin inputs crossing into the core clock
  fcf_sync #(.W(17)) u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    ({supply_ok_i, flash_dq_i}),
    .sync_o     ({sup_s, dq_s})
  );

  // ==========================================================
  // command sequences
  // number of write cycles an operation needs
  function automatic logic [1:0] seq_len(input fcf_op_t op);
    unique case (op)
      OP_WRITE, OP_RESET, OP_UNPROT: seq_len = 2'd1;
      OP_IDENT:                      seq_len = 2'd3;
      default:                       seq_len = 2'd0;
    endcase
  endfunction

  // address of write cycle stp; unlock pair is width dependent
  function automatic logic [19:0] seq_addr(input fcf_op_t op, input logic [1:0] stp,
                                           input logic bm, input logic [19:0] a);
    seq_addr = a;
    if (op == OP_IDENT) begin
      seq_addr = (stp == 2'd1) ? (bm ? UNL2_B : UNL2_W) : (bm ? UNL1_B : UNL1_W); // RULE_11
    end else if (op == OP_RESET) begin
      seq_addr = '0; // RULE_16
    end else if (op == OP_UNPROT) begin
      seq_addr = (a & ~ID_OFS_MASK) | HV_A6 | HV_A1;
    end
  endfunction

  function automatic logic [15:0] seq_data(input fcf_op_t op, input logic [1:0] stp,
                                           input logic [15:0] w);
    unique case (op)
      OP_IDENT:  seq_data = (stp == 2'd0) ? DAT_UNL1 : ((stp == 2'd1) ? DAT_UNL2 : DAT_IDENT);
      OP_RESET:  seq_data = DAT_RESET;
      OP_UNPROT: seq_data = DAT_UNPROT;
      default:   seq_data = w;
    endcase
  endfunction

  // address for an id read by either method
  function automatic logic [19:0] id_addr(input fcf_sel_t s, input logic hv,
                                          input logic bm, input logic [19:0] a);
    logic [19:0] sect;
    sect = a & ~ID_OFS_MASK;
    if (hv) begin
      // RULE_01 only A6, A1 and A0 matter; A6 stays low
      unique case (s)
        SEL_PART: id_addr = HV_A0;
        SEL_PROT: id_addr = sect | HV_A1; // RULE_02
        default:  id_addr = ID_MAKER;
      endcase
    end else begin
      unique case (s) // RULE_21
        SEL_PART: id_addr = bm ? ID_PART_B : ID_PART_W;
        SEL_PROT: id_addr = sect | (bm ? ID_PROT_B : ID_PROT_W);
        default:  id_addr = ID_MAKER;
      endcase
    end
  endfunction

  // ==========================================================
  // next-state logic: bus slave and pin sequencer
  always_comb begin
    logic    wr;
    logic    rd;
    logic    start;
    fcf_op_t nop;
    wr    = 1'b0;
    rd    = 1'b0;
    start = 1'b0;
    nop   = fcf_op_t'(wb_dat_i[CMD_OP_LSB +: 3]);
    d     = q;
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    wr    = d.ack & wb_we_i;
    rd    = d.ack & ~wb_we_i;
    d.dat = '0;
    // register reads; unmapped offsets read zero
    if (rd) begin
      unique case (wb_adr_i)
        REG_CTRL:  d.dat = {29'h0, q.ctrl};
        REG_ADDR:  d.dat = {12'h0, q.addr};
        REG_WDATA: d.dat = {16'h0, q.wdata};
        REG_STAT:  d.dat = {27'h0, q.tmo, sup_s, q.err, q.idm, q.st != ST_IDLE};
        REG_RDATA: d.dat = {16'h0, q.rdata};
        REG_PROT:  d.dat = {13'h0, q.prot};
        default:   d.dat = '0;
      endcase
    end
    // register writes; sel lane 0 alone gates every field, whatever its width
    if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        REG_CTRL:  d.ctrl = wb_dat_i[2:0];
        REG_ADDR:  d.addr = wb_dat_i[19:0];
        REG_WDATA: d.wdata = wb_dat_i[15:0];
        REG_PROT:  d.prot = wb_dat_i[18:0];
        REG_CMD:   start = 1'b1;
        default:   ;
      endcase
    end
    // command launch; busy or refused commands set the error flag
    if (start) begin
      d.err = 1'b0;
      if (q.st != ST_IDLE || nop == OP_NONE) begin
        d.err = 1'b1;
      end else if (!sup_s && nop != OP_HWRST) begin
        d.err = 1'b1; // RULE_08
      end else if (nop == OP_UNPROT && !(&q.prot)) begin
        d.err = 1'b1; // RULE_06
      end else if (nop == OP_IDREAD && !wb_dat_i[CMD_HV] && !q.idm) begin
        d.err = 1'b1; // RULE_03
      end else begin
        d.op   = nop;
        d.sel  = fcf_sel_t'(wb_dat_i[CMD_SEL_LSB +: 2]);
        d.hv   = wb_dat_i[CMD_HV];
        d.sidx = wb_dat_i[CMD_SIDX_LSB +: 5];
        d.stp  = '0;
        if (nop == OP_HWRST) begin
          d.st = ST_CLR;
          d.cnt = RP_CYC + 8'd1;
        end else if (seq_len(nop) != 2'd0) begin
          d.st = ST_WSET;
        end else begin
          d.st = ST_RSET;
        end
      end
    end
    // pin sequencer
    unique case (q.st)
      // idle keeps whatever the command launch chose
      ST_IDLE: ;
      ST_WSET: begin
        // address and data settle with output enable high
        d.fa    = seq_addr(q.op, q.stp, q.ctrl[CTRL_BYTE], q.addr);
        d.fd    = seq_data(q.op, q.stp, q.wdata);
        d.dq_oe = 1'b1;
        d.oe_n  = 1'b1;
        d.st    = ST_WLOW;
        d.cnt   = WP_CYC + 8'd1; // one extra count so the strobe stays low the full time
      end
      ST_WLOW: begin
        d.ce_n = 1'b0; // RULE_09
        d.we_n = 1'b0;
        d.cnt  = q.cnt - 8'd1;
        if (q.cnt == 8'd1) begin
          d.we_n = 1'b1; // RULE_12
          d.ce_n = 1'b1;
          d.st   = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        // data held one cycle past the rising strobes
        d.stp = q.stp + 2'd1;
        if (q.stp + 2'd1 < seq_len(q.op)) begin
          d.st = ST_WSET;
        end else begin
          d.st    = ST_IDLE;
          d.dq_oe = 1'b0;
          if (q.op == OP_IDENT) begin
            d.idm = 1'b1;
          end
          if (q.op == OP_RESET) begin
            d.idm = 1'b0; // RULE_19
            d.tmo = 1'b0;
          end
        end
      end
      ST_RSET: begin
        d.fa    = (q.op == OP_IDREAD) ? id_addr(q.sel, q.hv, q.ctrl[CTRL_BYTE], q.addr) : q.addr;
        d.a_hv  = (q.op == OP_IDREAD) && q.hv;
        d.dq_oe = 1'b0;
        d.st    = ST_RWAIT;
        d.cnt   = ACC_CYC + 8'd1;
      end
      ST_RWAIT: begin
        d.ce_n = 1'b0;
        d.oe_n = 1'b0;
        d.cnt  = q.cnt - 8'd1;
        if (q.cnt == 8'd1) begin
          d.ce_n  = 1'b1;
          d.oe_n  = 1'b1;
          d.a_hv  = 1'b0;
          d.rdata = dq_s;
          d.st    = ST_IDLE;
          if (q.op == OP_IDREAD && q.sel == SEL_PROT && q.sidx < 5'(NSECT)) begin
            d.prot[q.sidx] = dq_s[0]; // RULE_23
          end
          if (q.op == OP_READ && dq_s[TMO_BIT]) begin
            d.tmo = 1'b1;
            if (q.ctrl[CTRL_AUTO]) begin
              d.op  = OP_RESET; // RULE_15 RULE_20
              d.stp = '0;
              d.st  = ST_WSET;
            end
          end
        end
      end
      ST_CLR: begin
        // everything else released while the clear pin is low
        d.clr_n = 1'b0; // RULE_22
        d.ce_n  = 1'b1;
        d.oe_n  = 1'b1;
        d.we_n  = 1'b1;
        d.dq_oe = 1'b0;
        d.a_hv  = 1'b0;
        d.idm   = 1'b0;
        d.cnt   = q.cnt - 8'd1;
        if (q.cnt == 8'd1) begin
          d.clr_n = 1'b1;
          d.st    = ST_REC;
          d.cnt   = RH_CYC;
        end
      end
      ST_REC: begin
        d.cnt = q.cnt - 8'd1;
        if (q.cnt == 8'd1) begin
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // pin levels taken from the next state so both leave a flip-flop
    d.chv = d.a_hv ? 1'b0 : (d.ctrl[CTRL_TUNP] | (d.op == OP_UNPROT && d.st != ST_IDLE)); // RULE_07
    d.wm  = ~d.ctrl[CTRL_BYTE];
  end

  // ==========================================================
  // state register; reset leaves every strobe high
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.op    <= OP_NONE;
      q.ctrl  <= CTRL_RST;
      q.ce_n  <= 1'b1; // RULE_10
      q.oe_n  <= 1'b1;
      q.we_n  <= 1'b1;
      q.clr_n <= 1'b1;
      q.wm    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign wb_dat_o          = q.dat;
  assign wb_ack_o          = q.ack;
  assign flash_addr_o      = q.fa;
  assign flash_dq_o        = q.fd;
  assign flash_dq_oe_o     = q.dq_oe;
  assign flash_ce_n_o      = q.ce_n;
  assign flash_oe_n_o      = q.oe_n;
  assign flash_we_n_o      = q.we_n;
  assign flash_clear_n_o   = q.clr_n;
  assign flash_word_mode_o = q.wm;
  // elevated clear pin for temporary unprotect or the unprotect cycle
  assign flash_clear_hv_o  = q.chv; // RULE_07
  assign flash_id_hv_o     = q.a_hv;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  logic cmd_wr;
  assign cmd_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~q.ack & wb_sel_i[0] & (wb_adr_i == REG_CMD);

  sequence s_clr_low;
    !flash_clear_n_o [*8];
  endsequence
  sequence s_strobe_low;
    !flash_we_n_o ##1 !flash_we_n_o;
  endsequence

  chk_write_gate: assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o) // RULE_09
    else $error("write strobe low without write conditions");
  chk_addr_hold: assert property (s_strobe_low |-> $stable(flash_addr_o) && $stable(flash_dq_o)) // RULE_12
    else $error("address or data moved during write pulse");
  chk_data_after: assert property ($rose(flash_we_n_o) |-> flash_dq_oe_o ##1 $stable(flash_dq_o)) // RULE_12
    else $error("data released at strobe rise");
  chk_hv_addr: assert property (flash_id_hv_o && q.sel != SEL_PROT |-> flash_addr_o[19:2] == 18'h0) // RULE_01
    else $error("high-voltage id address not clean");
  chk_lockout_refuse: assert property (cmd_wr && !sup_s && q.st == ST_IDLE && wb_dat_i[2:0] != OP_HWRST
                                       |=> q.err && q.st == ST_IDLE) // RULE_08
    else $error("command taken during supply lockout");
  chk_unprot_gate: assert property (q.st == ST_WLOW && q.op == OP_UNPROT |-> &q.prot) // RULE_06
    else $error("unprotect issued with unlocked sector");
  chk_clear_pulse: assert property ($fell(flash_clear_n_o) |-> s_clr_low ##0 flash_ce_n_o) // RULE_22
    else $error("clear pulse too short");
  chk_reset_data: assert property (!flash_we_n_o && q.op == OP_RESET |-> flash_dq_o == DAT_RESET) // RULE_16
    else $error("reset command data wrong");
  chk_idm_exit: assert property ($fell(q.idm) |-> $past(q.op) == OP_RESET || $past(q.st) == ST_CLR) // RULE_19
    else $error("id mode left without reset");
  chk_tmo_reset: assert property ($rose(q.tmo) && q.ctrl[CTRL_AUTO] |-> ##[1:20] !flash_we_n_o) // RULE_20
    else $error("no reset after timeout flag");
endmodule

// File: fcf_flash_model.sv
// behavioural model of the flash command front end seen from its pins
`timescale 1ns/1ps
module fcf_flash_model
  import fcf_pkg::*;
#(
  parameter logic [7:0]  MAKER_CODE = 8'h3c,   // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h2e71 // arbitrary value
) (
  input  wire logic [19:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        clear_n_i,
  input  wire logic        clear_hv_i,
  input  wire logic        id_hv_i,
  input  wire logic        word_i,
  input  wire logic        supply_ok_i,
  input  wire logic [15:0] host_dq_i,
  input  wire logic        host_oe_i,
  output logic      [15:0] dq_o
);
  // ==========================================================
  // state: starts in read-array, sectors shipped unlocked
  logic [NSECT-1:0] prot_q = '0;
  logic             idm_q  = 1'b0;
  logic             tmo_q  = 1'b0;
  logic             act_q  = 1'b0;
  logic [1:0]       seq_q  = 2'h0;
  logic [19:0]      lat_a, last_a;
  logic [15:0]      last_d, rd, hold_q = 16'h0;
  int               viol   = 0;
  int               locked_wr = 0;  // writes refused by a locked sector
  wire rd_en = !ce_n_i && !oe_n_i && we_n_i && clear_n_i;

  function automatic int sect(input logic [19:0] a);
    return a[19:15] % NSECT;
  endfunction

  // address taken at the later falling edge; oe low here is a host fault
  always @(negedge we_n_i or negedge ce_n_i) begin
    if (!we_n_i && !ce_n_i && clear_n_i) begin
      lat_a = addr_i;
      act_q = 1'b1;
      if (!oe_n_i) viol++;
    end
  end

  // data taken at the first rising edge, then decoded
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (act_q) begin
      act_q = 1'b0;
      last_a = lat_a;
      last_d = host_dq_i;
      if (prot_q[sect(lat_a)] && !clear_hv_i) locked_wr++;
      if (!supply_ok_i) begin
        seq_q = 2'h0;
      end else if (host_dq_i[7:0] == 8'hf0) begin
        seq_q = 2'h0;
        idm_q = 1'b0;
        tmo_q = 1'b0;
      end else if (host_dq_i[7:0] == 8'h60 && clear_hv_i) begin
        if (prot_q != '1) viol++;
        prot_q = '0;
      end else if (!idm_q) begin
        case (seq_q)
          2'h0: seq_q = (lat_a[11:0] == (word_i ? 12'h555 : 12'haaa) && host_dq_i[7:0] == 8'haa) ? 2'h1 : 2'h0;
          2'h1: seq_q = (lat_a[11:0] == (word_i ? 12'h2aa : 12'h555) && host_dq_i[7:0] == 8'h55) ? 2'h2 : 2'h0;
          default: begin
            idm_q = lat_a[11:0] == (word_i ? 12'h555 : 12'haaa) && host_dq_i[7:0] == 8'h90;
            seq_q = 2'h0;
          end
        endcase
      end
    end
  end

  // clear pin ends every sequence at once
  always @(negedge clear_n_i) begin
    seq_q = 2'h0;
    idm_q = 1'b0;
    act_q = 1'b0;
  end

  // read mux: hv id, in-system id, or array pattern with the timeout flag
  always_comb begin
    rd = addr_i[15:0] ^ 16'h5a5a;
    rd[TMO_BIT] = tmo_q;
    if (id_hv_i) begin
      case ({addr_i[6], addr_i[1], addr_i[0]})
        3'b000:  rd = {8'h00, MAKER_CODE};
        3'b001:  rd = PART_CODE;
        3'b010:  rd = {15'h0, prot_q[sect(addr_i)]};
        default: rd = 16'h0;
      endcase
    end else if (idm_q) begin
      if (addr_i[7:0] == 8'h00) rd = {8'h00, MAKER_CODE};
      else if (addr_i[7:0] == (word_i ? 8'h01 : 8'h02)) rd = PART_CODE;
      else if (addr_i[7:0] == (word_i ? 8'h02 : 8'h04)) rd = {15'h0, prot_q[sect(addr_i)]};
      else rd = 16'h0;
    end
  end

  // a released bus shows the inverse of the last value, never a stale copy
  always @(negedge rd_en) hold_q = rd;
  assign dq_o = rd_en ? rd : (host_oe_i ? host_dq_i : ~hold_q);
endmodule

// File: fcf_pkg.sv
// shared constants and types for the flash command front-end host controller
package fcf_pkg;
  // ==========================================================
  // clock and pin timing
  localparam int CLK_MHZ  = 100;
  localparam int T_WP_NS  = 50;   // write strobe low time
  localparam int T_ACC_NS = 100;  // read access time
  localparam int T_RP_NS  = 500;  // hardware clear pulse width
  localparam int T_RH_NS  = 200;  // recovery after hardware clear
  localparam logic [7:0] WP_CYC  = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000 + 2);
  localparam logic [7:0] RP_CYC  = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RH_CYC  = 8'((T_RH_NS * CLK_MHZ + 999) / 1000);

  // ==========================================================
  // register map (byte offsets) and fields
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_ADDR  = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_PROT  = 8'h18;
  localparam int CTRL_BYTE = 0;   // byte-wide addressing of id offsets
  localparam int CTRL_TUNP = 1;   // temporary unprotect on clear pin
  localparam int CTRL_AUTO = 2;   // automatic reset on timeout flag
  localparam int CMD_OP_LSB = 0;  // [2:0] operation
  localparam int CMD_SEL_LSB = 3; // [4:3] id selector
  localparam int CMD_HV = 5;      // high-voltage id method
  localparam int CMD_SIDX_LSB = 6;// [10:6] sector index
  localparam int STAT_BUSY = 0;
  localparam int STAT_IDM  = 1;
  localparam int STAT_ERR  = 2;
  localparam int STAT_SUP  = 3;
  localparam int STAT_TMO  = 4;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int NSECT = 19;

  // ==========================================================
  // command codes and device addresses
  localparam logic [19:0] UNL1_W = 20'h00555;
  localparam logic [19:0] UNL2_W = 20'h002aa;
  localparam logic [19:0] UNL1_B = 20'h00aaa;
  localparam logic [19:0] UNL2_B = 20'h00555;
  localparam logic [15:0] DAT_UNL1 = 16'h00aa;
  localparam logic [15:0] DAT_UNL2 = 16'h0055;
  localparam logic [15:0] DAT_IDENT = 16'h0090;
  localparam logic [15:0] DAT_RESET = 16'h00f0;
  localparam logic [15:0] DAT_UNPROT = 16'h0060;
  localparam logic [19:0] ID_OFS_MASK = 20'h000ff;
  localparam logic [19:0] ID_MAKER = 20'h00000;
  localparam logic [19:0] ID_PART_W = 20'h00001;
  localparam logic [19:0] ID_PART_B = 20'h00002;
  localparam logic [19:0] ID_PROT_W = 20'h00002;
  localparam logic [19:0] ID_PROT_B = 20'h00004;
  localparam logic [19:0] HV_A6 = 20'h00040;
  localparam logic [19:0] HV_A1 = 20'h00002;
  localparam logic [19:0] HV_A0 = 20'h00001;
  localparam int TMO_BIT = 5;     // timeout flag bit of the low data byte

  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_RESET = 3'h2, OP_IDENT = 3'h3,
    OP_IDREAD = 3'h4, OP_HWRST = 3'h5, OP_UNPROT = 3'h6, OP_NONE = 3'h7
  } fcf_op_t;
  typedef enum logic [1:0] {SEL_MAKER = 2'h0, SEL_PART = 2'h1, SEL_PROT = 2'h2, SEL_RSV = 2'h3} fcf_sel_t;
endpackage

// File: fcf_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fcf_sync #(
  parameter int W = 17
) (
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule

// File: test_fcf_ctrl.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_fcf_ctrl;
  import fcf_pkg::*;
  localparam logic [7:0]  MK = 8'h3c;   // arbitrary value
  localparam logic [15:0] PC = 16'h2e71; // arbitrary value
  logic        core_clk_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0, sup = 1;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wd = 0, rd;
  wire  [31:0] wb_dat_o;
  wire  [19:0] fa;
  wire  [15:0] fdq, fdi;
  wire         wb_ack_o, foe, ce_n, oe_n, we_n, clr_n, chv, ihv, wm;
  int          n_mismatch = 0, num_checks = 0;

  fcf_ctrl fcf_ctrl_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_addr_o(fa), .flash_dq_o(fdq), .flash_dq_oe_o(foe), .flash_dq_i(fdi), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_clear_n_o(clr_n), .flash_clear_hv_o(chv),
    .flash_id_hv_o(ihv), .flash_word_mode_o(wm), .supply_ok_i(sup));
  fcf_flash_model #(.MAKER_CODE(MK), .PART_CODE(PC)) fcf_flash_model_i (.addr_i(fa), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .clear_n_i(clr_n), .clear_hv_i(chv), .id_hv_i(ihv), .word_i(wm),
    .supply_ok_i(sup), .host_dq_i(fdq), .host_oe_i(foe), .dq_o(fdi));

  // free-running 100 MHz clock
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================
  // bus tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
    // no cycle count assumed; only the watchdog ends a hung wait
    do @(posedge core_clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // launch an operation and poll busy until it drops
  task automatic cmd(input fcf_op_t op, input fcf_sel_t s, input logic hv, input logic [4:0] sx);
    wb(1, REG_CMD, {21'h0, sx, hv, s, op});
    do wb(0, REG_STAT, 32'h0);
    while (rd[STAT_BUSY] !== 1'b0);
  endtask

  // watchdog well beyond the few hundred cycles of the run
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_mismatch++;
    conclude();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (20) @(posedge core_clk_i);
    resetn_i <= 1;
    repeat (3) @(posedge core_clk_i);
    rreg(REG_CTRL, 32'h0);
    rreg(REG_STAT, 32'h8);
    rreg(REG_PROT, 32'h0);
    wb(1, 8'h1c, 32'h5);
    rreg(8'h1c, 32'h0);
    $display("test registers done");
    // in-system identification, then only reset leaves it
    cmd(OP_IDENT, SEL_MAKER, 0, 0);
    rreg(REG_STAT, 32'ha);
    cmd(OP_IDREAD, SEL_MAKER, 0, 0);
    rreg(REG_RDATA, {24'h0, MK});
    cmd(OP_IDREAD, SEL_PART, 0, 0);
    rreg(REG_RDATA, {16'h0, PC});
    fcf_flash_model_i.prot_q[3] = 1'b1;
    wb(1, REG_ADDR, 32'h18000);
    cmd(OP_IDREAD, SEL_PROT, 0, 3);
    rreg(REG_RDATA, 32'h1);
    rreg(REG_PROT, 32'h8);
    wb(1, REG_WDATA, 32'h12);
    cmd(OP_WRITE, SEL_MAKER, 0, 0);
    rreg(REG_STAT, 32'ha);
    cmd(OP_RESET, SEL_MAKER, 0, 0);
    rreg(REG_STAT, 32'h8);
    cmd(OP_IDREAD, SEL_MAKER, 0, 0);
    rreg(REG_STAT, 32'hc);
    wb(1, REG_CTRL, 32'h1);
    cmd(OP_IDENT, SEL_MAKER, 0, 0);
    cmd(OP_IDREAD, SEL_PART, 0, 0);
    rreg(REG_RDATA, {16'h0, PC});
    cmd(OP_RESET, SEL_MAKER, 0, 0);
    wb(1, REG_CTRL, 32'h0);
    $display("test identify done");
    // high-voltage method outside identification mode
    cmd(OP_IDREAD, SEL_PROT, 1, 3);
    rreg(REG_RDATA, 32'h1);
    cmd(OP_IDREAD, SEL_PART, 1, 0);
    rreg(REG_RDATA, {16'h0, PC});
    $display("test high voltage done");
    wb(1, REG_ADDR, 32'h12345);
    wb(1, REG_WDATA, 32'hbeef);
    cmd(OP_WRITE, SEL_MAKER, 0, 0);
    `CHK(fcf_flash_model_i.last_a, 20'h12345)
    `CHK(fcf_flash_model_i.last_d, 16'hbeef)
    $display("test write done");
    // timeout flag seen on an array read triggers a reset write
    wb(1, REG_CTRL, 32'h4);
    fcf_flash_model_i.tmo_q = 1'b1;
    wb(1, REG_ADDR, 32'h00100);
    cmd(OP_READ, SEL_MAKER, 0, 0);
    rreg(REG_RDATA, {16'h0, 16'h0100 ^ 16'h5a5a | 16'h0020});
    rreg(REG_STAT, 32'h8);
    `CHK(fcf_flash_model_i.tmo_q, 1'b0)
    // without auto reset the flag stays visible until a reset command
    wb(1, REG_CTRL, 32'h0);
    fcf_flash_model_i.tmo_q = 1'b1;
    cmd(OP_READ, SEL_MAKER, 0, 0);
    rreg(REG_STAT, 32'h18);
    $display("test timeout done");
    // unprotect refused until every sector is locked
    cmd(OP_UNPROT, SEL_MAKER, 0, 0);
    `CHK(rd[STAT_ERR], 1'b1)
    fcf_flash_model_i.prot_q = '1;
    wb(1, REG_PROT, 32'h7ffff);
    cmd(OP_UNPROT, SEL_MAKER, 0, 0);
    `CHK(rd[STAT_ERR], 1'b0)
    `CHK(fcf_flash_model_i.prot_q, 19'h0)
    $display("test unprotect done");
    sup <= 0;
    repeat (4) @(posedge core_clk_i);
    wb(1, REG_WDATA, 32'h77);
    cmd(OP_WRITE, SEL_MAKER, 0, 0);
    `CHK(rd[STAT_SUP:STAT_ERR], 2'b01)
    `CHK(fcf_flash_model_i.last_d, DAT_UNPROT)
    sup <= 1;
    repeat (4) @(posedge core_clk_i);
    $display("test supply done");
    // clear pulse drops identification mode; invalid op refused
    cmd(OP_IDENT, SEL_MAKER, 0, 0);
    cmd(OP_HWRST, SEL_MAKER, 0, 0);
    rreg(REG_STAT, 32'h18);
    `CHK(fcf_flash_model_i.idm_q, 1'b0)
    cmd(OP_NONE, SEL_MAKER, 0, 0);
    `CHK(rd[STAT_ERR], 1'b1)
    `CHK(fcf_flash_model_i.viol, 0)
    `CHK(fcf_flash_model_i.locked_wr, 1)
    $display("test clear done");
    conclude();
  end
endmodule
